/* File: inc/phase_fault_pkg.sv */
`default_nettype none
package phase_fault_pkg;
  localparam int PHASE_COUNT = 4;
  localparam int SYNC_DEPTH = 3;
  localparam int REG_WIDTH = 8;
  localparam logic [7:0] OFF_LEVEL_ONE = 8'hd9;
  localparam logic [7:0] OFF_LEVEL_TWO = 8'hda;
  localparam logic [7:0] OFF_SYS_STATUS = 8'hdc;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int BIT_DIRECTION = 0;
  localparam int BIT_POSITION_LO = 1;
  localparam int BIT_SWITCH_MODE = 3;
  localparam int BIT_PROTECT_MODE = 4;
  localparam int BIT_DRIVE_STYLE = 5;
  localparam int BIT_OUTPUT_READY = 7;
  localparam logic [1:0] POS_MASTER = 2'h0;

  typedef struct packed {
    logic [1:0] position;
    logic diode_emulation_n;
    logic hiccup;
    logic three_state;
  } strap_t;

  localparam strap_t STRAP_RESET = '0;

  typedef struct packed {
    logic output_ready;
    logic reserved;
    logic three_state;
    logic hiccup;
    logic diode_emulation_n;
    logic [1:0] position;
    logic step_up;
  } sys_status_t;
endpackage
`default_nettype wire

/* File: rtl/phase_fault_status.sv */
`timescale 1ns/1ps
`default_nettype none
module phase_fault_status #(
  parameter int PHASES = phase_fault_pkg::PHASE_COUNT
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [PHASES-1:0] overcurrent_level_one_pin,
  input wire logic [PHASES-1:0] overcurrent_level_two_pin,
  input wire logic direction_select_pin,
  input wire logic [1:0] position_strap_pin,
  input wire logic mode_strap_pin,
  input wire logic protection_strap_pin,
  input wire logic drive_style_strap_pin,
  input wire logic init_active,
  input wire logic pulse_ready,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  localparam int SYNC_W = 2 * PHASES + 6;

  generate
    if (PHASES < 1 || PHASES > phase_fault_pkg::REG_WIDTH)
    begin : g_bad
      $error("PHASES must lie between one and the register width");
    end
  endgenerate

  logic [SYNC_W-1:0] sync_level;
  logic [PHASES-1:0] lvl1_sync;
  logic [PHASES-1:0] lvl2_sync;
  logic dir_sync;
  phase_fault_pkg::strap_t strap_sync;
  logic [PHASES-1:0] lvl1_flags_ff;
  logic [PHASES-1:0] nxt_lvl1_flags;
  logic [PHASES-1:0] lvl2_flags_ff;
  logic [PHASES-1:0] nxt_lvl2_flags;
  phase_fault_pkg::strap_t strap_ff;
  phase_fault_pkg::sys_status_t sys_view;
  logic [7:0] reg_rdata_ff;
  logic [7:0] nxt_rdata;

  // Comparator outputs and straps are all asynchronous to this clock
  pin_sync3 #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin_in({overcurrent_level_one_pin, overcurrent_level_two_pin, direction_select_pin,
             position_strap_pin, mode_strap_pin, protection_strap_pin,
             drive_style_strap_pin}),
    .level_out(sync_level)
  );

  assign lvl1_sync = sync_level[SYNC_W-1 -: PHASES];
  assign lvl2_sync = sync_level[PHASES+5 -: PHASES];
  assign dir_sync = sync_level[5];
  assign strap_sync = sync_level[4:0];

  // Write of zero clears a flag; a fresh event in the same cycle wins
  always_comb
  begin
    nxt_lvl1_flags = lvl1_flags_ff;
    if (reg_wr && reg_addr == phase_fault_pkg::OFF_LEVEL_ONE)
      nxt_lvl1_flags = nxt_lvl1_flags & reg_wdata[PHASES-1:0];
    nxt_lvl1_flags = nxt_lvl1_flags | lvl1_sync;
  end

  always_comb
  begin
    nxt_lvl2_flags = lvl2_flags_ff;
    if (reg_wr && reg_addr == phase_fault_pkg::OFF_LEVEL_TWO)
      nxt_lvl2_flags = nxt_lvl2_flags & reg_wdata[PHASES-1:0];
    nxt_lvl2_flags = nxt_lvl2_flags | lvl2_sync;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      lvl1_flags_ff <= PHASES'(phase_fault_pkg::FLAGS_RESET);
    else if (clk_en)
      lvl1_flags_ff <= nxt_lvl1_flags;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      lvl2_flags_ff <= PHASES'(phase_fault_pkg::FLAGS_RESET);
    else if (clk_en)
      lvl2_flags_ff <= nxt_lvl2_flags;
  end

  // Straps follow the pins only during startup, frozen afterwards
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      strap_ff <= phase_fault_pkg::STRAP_RESET;
    else if (clk_en && init_active)
      strap_ff <= strap_sync;
  end

  always_comb
  begin
    sys_view.step_up = dir_sync;
    sys_view.position = strap_ff.position;
    sys_view.diode_emulation_n = strap_ff.diode_emulation_n;
    sys_view.hiccup = strap_ff.hiccup;
    sys_view.three_state = strap_ff.three_state;
    sys_view.reserved = 1'b0;
    // Slaves do not own the driver enable, so never report ready
    sys_view.output_ready = pulse_ready &&
                            strap_ff.position == phase_fault_pkg::POS_MASTER;
  end

  always_comb
  begin
    case (reg_addr)
      phase_fault_pkg::OFF_LEVEL_ONE: nxt_rdata = 8'(lvl1_flags_ff);
      phase_fault_pkg::OFF_LEVEL_TWO: nxt_rdata = 8'(lvl2_flags_ff);
      phase_fault_pkg::OFF_SYS_STATUS: nxt_rdata = sys_view;
      default: nxt_rdata = phase_fault_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_ff <= 8'h00;
    else if (clk_en && reg_rd)
      reg_rdata_ff <= nxt_rdata;
  end

  assign reg_rdata = reg_rdata_ff;

  logic [7:0] last_addr_ff;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      last_addr_ff <= 8'h00;
    else if (clk_en && reg_rd)
      last_addr_ff <= reg_addr;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_lvl1_flag_set: assert property (clk_en |=>
    ((lvl1_flags_ff & $past(lvl1_sync)) == $past(lvl1_sync)))
    else $error("level-one flag missed an event");
  a_lvl1_flag_hold: assert property (
    !(clk_en && reg_wr && reg_addr == phase_fault_pkg::OFF_LEVEL_ONE) |=>
    (($past(lvl1_flags_ff) & ~lvl1_flags_ff) == '0))
    else $error("level-one flag dropped without a write");
  a_lvl1_flag_clear: assert property (
    (clk_en && reg_wr && reg_addr == phase_fault_pkg::OFF_LEVEL_ONE && lvl1_sync == '0) |=>
    (lvl1_flags_ff == ($past(lvl1_flags_ff) & $past(reg_wdata[PHASES-1:0]))))
    else $error("level-one flag write clear wrong");
  a_lvl2_flag_set: assert property (clk_en |=>
    ((lvl2_flags_ff & $past(lvl2_sync)) == $past(lvl2_sync)))
    else $error("level-two flag missed an event");
  a_lvl2_flag_hold: assert property (
    !(clk_en && reg_wr && reg_addr == phase_fault_pkg::OFF_LEVEL_TWO) |=>
    (($past(lvl2_flags_ff) & ~lvl2_flags_ff) == '0))
    else $error("level-two flag dropped without a write");
  a_lvl2_flag_clear: assert property (
    (clk_en && reg_wr && reg_addr == phase_fault_pkg::OFF_LEVEL_TWO && lvl2_sync == '0) |=>
    (lvl2_flags_ff == ($past(lvl2_flags_ff) & $past(reg_wdata[PHASES-1:0]))))
    else $error("level-two flag write clear wrong");
  a_dir_readback: assert property (
    (clk_en && reg_rd && reg_addr == phase_fault_pkg::OFF_SYS_STATUS) |=>
    reg_rdata[phase_fault_pkg::BIT_DIRECTION] == $past(dir_sync))
    else $error("direction bit not live");
  a_pos_readback: assert property (
    (clk_en && reg_rd && reg_addr == phase_fault_pkg::OFF_SYS_STATUS) |=>
    reg_rdata[phase_fault_pkg::BIT_POSITION_LO +: 2] == $past(strap_ff.position))
    else $error("position field wrong");
  a_strap_hold: assert property ((!init_active)[*2] |-> $stable(strap_ff))
    else $error("strap changed after startup");
  a_strap_capture: assert property ((clk_en && init_active) |=>
    strap_ff == $past(strap_sync))
    else $error("strap not captured during startup");
  a_mode_switch: assert property (
    (clk_en && reg_rd && reg_addr == phase_fault_pkg::OFF_SYS_STATUS) |=>
    reg_rdata[phase_fault_pkg::BIT_SWITCH_MODE] == $past(strap_ff.diode_emulation_n))
    else $error("switching mode bit wrong");
  a_mode_protect: assert property (
    (clk_en && reg_rd && reg_addr == phase_fault_pkg::OFF_SYS_STATUS) |=>
    reg_rdata[phase_fault_pkg::BIT_PROTECT_MODE] == $past(strap_ff.hiccup))
    else $error("protection mode bit wrong");
  a_mode_drive: assert property (
    (clk_en && reg_rd && reg_addr == phase_fault_pkg::OFF_SYS_STATUS) |=>
    reg_rdata[phase_fault_pkg::BIT_DRIVE_STYLE] == $past(strap_ff.three_state))
    else $error("drive style bit wrong");
  a_ready_slave: assert property (
    (clk_en && reg_rd && reg_addr == phase_fault_pkg::OFF_SYS_STATUS) |=>
    reg_rdata[phase_fault_pkg::BIT_OUTPUT_READY] ==
    ($past(pulse_ready) && $past(strap_ff.position) == phase_fault_pkg::POS_MASTER))
    else $error("ready bit wrong");
  a_status_rsvd: assert property (
    (clk_en && reg_rd && reg_addr == phase_fault_pkg::OFF_SYS_STATUS) |=>
    reg_rdata[6] == 1'b0)
    else $error("status reserved bit not zero");
  a_rsvd_zero: assert property (
    (last_addr_ff != phase_fault_pkg::OFF_SYS_STATUS) |->
    (reg_rdata >> PHASES) == 8'h00)
    else $error("reserved bits not zero");

  c_lvl1_event: cover property (clk_en && lvl1_sync != '0 ##1 lvl1_flags_ff != '0);
  c_clear_flag: cover property (clk_en && reg_wr && reg_addr == phase_fault_pkg::OFF_LEVEL_TWO
    && lvl2_flags_ff != '0 ##1 lvl2_flags_ff == '0);
  c_set_wins: cover property (clk_en && reg_wr && reg_addr == phase_fault_pkg::OFF_LEVEL_ONE
    && reg_wdata == 8'h00 && lvl1_sync != '0);
  c_master_ready: cover property (clk_en && reg_rd && pulse_ready &&
    reg_addr == phase_fault_pkg::OFF_SYS_STATUS &&
    strap_ff.position == phase_fault_pkg::POS_MASTER);
  c_slave_read: cover property (clk_en && reg_rd && pulse_ready &&
    reg_addr == phase_fault_pkg::OFF_SYS_STATUS && strap_ff.position != 2'h0);
endmodule
`default_nettype wire

/* File: rtl/pin_sync3.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] level_ff;

  generate
    if (WIDTH < 1)
    begin : g_bad
      $error("pin_sync3 needs WIDTH of at least one");
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end
    else if (clk_en)
    begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Change taken only where stages two and three agree
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      level_ff <= '0;
    else if (clk_en)
      level_ff <= (s2_ff & s3_ff) | (level_ff & (s2_ff | s3_ff));
  end

  assign level_out = level_ff;
endmodule
`default_nettype wire

/* File: testbench/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clock,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // Called just after a rising edge; idle edge after keeps strobes from re-assigning
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clock);
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0] ov1 = 4'h0;
  logic [3:0] ov2 = 4'h0;
  logic dir = 1'b0;
  logic [1:0] pos = 2'h0;
  logic mode = 1'b0;
  logic prot = 1'b0;
  logic drv = 1'b0;
  logic init = 1'b0;
  logic prdy = 1'b0;
  wire logic [7:0] addr;
  wire logic [7:0] wdata;
  wire logic [7:0] rdata;
  wire logic wr;
  wire logic rd;
  int error_cnt = 0;
  int checks_done = 0;
  int seed;
  logic rd_d = 1'b0;
  logic [7:0] e;
  logic [31:0] r;
  logic [7:0] exp_q[$];
  always #2 clock = ~clock;
  host_model host (.clock(clock), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd));
  phase_fault_status dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .overcurrent_level_one_pin(ov1), .overcurrent_level_two_pin(ov2),
    .direction_select_pin(dir), .position_strap_pin(pos), .mode_strap_pin(mode),
    .protection_strap_pin(prot), .drive_style_strap_pin(drv), .init_active(init),
    .pulse_ready(prdy), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd),
    .reg_rdata(rdata));
  task automatic step(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] v);
    exp_q.push_back(v);
    host.xfer(1'b0, a, 8'h00);
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Read data lands on the same edge that takes the strobe
  always @(posedge clock) rd_d <= rd & clk_en;
  always @(negedge clock)
    if (rd_d)
    begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hee;
      checks_done++;
      if (rdata !== e)
      begin
        error_cnt++;
        $display("BAD t=%0t got %h exp %h", $time, rdata, e);
      end
    end
  task automatic fault(input logic two, input logic [3:0] pat, input logic [7:0] keep);
    logic [7:0] a;
    a = two ? 8'hda : 8'hd9;
    if (two) ov2 <= pat;
    else ov1 <= pat;
    step(6);
    ov1 <= 4'h0;
    ov2 <= 4'h0;
    // Synced event still high here, so this clear must lose
    host.xfer(1'b1, a, 8'h00);
    step(6);
    chk(a, {4'h0, pat});
    chk(two ? 8'hd9 : 8'hda, 8'h00);
    host.xfer(1'b1, a, 8'hff);
    chk(a, {4'h0, pat});
    clk_en <= 1'b0;
    host.xfer(1'b1, a, 8'h00);
    clk_en <= 1'b1;
    chk(a, {4'h0, pat});
    host.xfer(1'b1, a, keep);
    chk(a, {4'h0, pat} & keep);
    host.xfer(1'b1, a, 8'h00);
    chk(a, 8'h00);
  endtask
  initial
  begin
    seed = $urandom(5);
    step(12);
    rst_n <= 1'b1;
    step(1);
    chk(8'hd9, 8'h00);
    chk(8'hda, 8'h00);
    chk(8'hdc, 8'h00);
    chk(8'hdb, 8'h00);
    repeat (3)
    begin
      r = $urandom;
      fault(1'b0, r[3:0] | 4'h1, r[15:8]);
      fault(1'b1, r[7:4] | 4'h8, r[23:16]);
    end
    for (int p = 0; p < 4; p++)
    begin
      r = $urandom;
      // Odd passes invert the random straps so both levels are seen
      r[3:0] = r[3:0] ^ {4{p[0]}};
      {pos, mode, prot, drv} <= {p[1:0], r[0], r[1], r[2]};
      dir <= r[3];
      prdy <= 1'b1;
      init <= 1'b1;
      step(8);
      init <= 1'b0;
      step(1);
      // Straps moving after init must not show
      {pos, mode, prot, drv} <= ~{p[1:0], r[0], r[1], r[2]};
      step(6);
      host.xfer(1'b1, 8'hdc, 8'hff);
      chk(8'hdc, {p == 0, 1'b0, r[2], r[1], r[0], p[1:0], r[3]});
    end
    step(4);
    report_and_stop();
  end
  initial
  begin
    #20000;
    error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire
